// ==== bps_map.svh ====
/*
  Constants for the burner pulse scheduler: register offsets,
  reset values and timing counts.
  Assumes a 25 MHz system clock and inclusion by bare name.
*/
`ifndef BPS_MAP_SVH
`define BPS_MAP_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define BPS_OFF_MODE 8'h00
`define BPS_OFF_COUNT 8'h04
`define BPS_OFF_PHASE_LO 8'h08
`define BPS_OFF_PHASE_HI 8'h0c
`define BPS_OFF_G1 8'h10
`define BPS_OFF_G2 8'h14
`define BPS_OFF_SRC 8'h18
`define BPS_OFF_STAT 8'h1c
`define BPS_OFF_SETPT 8'h20

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define BPS_RST_OPMODE 4'h1
`define BPS_RST_UNITID 6'h01
`define BPS_RST_REPRATE 6'h01
`define BPS_RST_FACTOR 7'h32
`define BPS_RST_LIMIT 7'h32
`define BPS_RST_DEAD 6'h00
`define BPS_RST_CONT 7'h00
`define BPS_RST_RATE 8'h1e

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define BPS_CLK_HZ 25000000
`define BPS_IND_SEC 3
`define BPS_IND_CYC (`BPS_IND_SEC * `BPS_CLK_HZ)
`define BPS_PHASE_STEPS 255
`define BPS_FULL_PCT 100
`define BPS_EMU_MODE 8'h6c
`define BPS_NEW_MODE 8'h80
`define BPS_MAX_OUTS 8

`endif

// ==== bps_pkg.sv ====
/*
  Types of the burner pulse scheduler.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package bps_pkg;
  // ---------------------------------------------------------------
  // heating and cooling zone
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    BPS_ZONE_DEAD,
    BPS_ZONE_COOL,
    BPS_ZONE_HEAT
  } bps_zone_t;
  typedef enum logic {BPS_SHOW_G1, BPS_SHOW_G2} bps_show_t;
endpackage

// ==== bps_ramp.sv ====
/*
  Three-point step ramp: turns open and close commands into a percent
  setting that travels 0..100 in the configured seconds.
  Assumes commands already synchronised to the system clock.
*/
`include "bps_map.svh"
module bps_ramp #(
  parameter int CLK_HZ = `BPS_CLK_HZ
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] rate_s_in,
  input wire logic open_in,
  input wire logic close_in,
  output logic [6:0] pct_out
);
  // ---------------------------------------------------------------
  // one percent step every rate_s * clk / 100 cycles
  // ---------------------------------------------------------------
  localparam int CYC_PER_PCT_S = CLK_HZ / `BPS_FULL_PCT;
  logic [31:0] cnt_r;
  logic [31:0] limit;
  logic step;
  logic [6:0] pct_nxt;
  assign limit = 32'(rate_s_in) * 32'(CYC_PER_PCT_S);
  assign step = (cnt_r + 32'h1 >= limit);
  // open rises, close falls, both or none holds; clamp at the ends
  assign pct_nxt = (!step || open_in == close_in) ? pct_out :
                   (open_in && pct_out < 7'd100) ? pct_out + 7'h1 :
                   (close_in && pct_out > 7'h0) ? pct_out - 7'h1 :
                   pct_out;

  // cycle counter runs only while a command is active
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= 32'h0;
      pct_out <= 7'h0;
    end else begin
      cnt_r <= (step || open_in == close_in) ? 32'h0 : cnt_r + 32'h1;
      pct_out <= pct_nxt;
    end
  end

  pct_range_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    pct_out <= 7'd100) else $error("ramp beyond full scale");
  ramp_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!open_in && !close_in) |=> $stable(pct_out))
    else $error("ramp moved without command");
endmodule

// ==== bps_top.sv ====
/*
  Burner pulse scheduler: AXI4-Lite register file, mode checks, setting
  selection, heating/cooling split, firing phase and indicator.
  Assumes pins reach it unsynchronised and one 25 MHz clock.
*/
// Added by the designer: the register addresses and register access over AXI4-Lite.
// Overview of operation
// - operating mode one to eight steers behaviour
// - unit identifier stored, no control effect
// - indicator zero alternates groups every three seconds
// - indicator one/two fixed; manual shows selected (manual_r is never set by any register, so manual never applies)
// - output counts over eight flag failure, flash
// - emulation modes two/four: outputs seven/eight switch
// - new mode: eight burners, dedicated switch outputs
// - key repeat rate one to thirty-two (code only stores the 6-bit field and reads it back, no key repeat)
// - cycle split in 255 phases, fire at phase
// - phase scales with cycle length
// - control factor sets max frequency point (code only stores and reads it back, no effect on firing)
// - limit splits heating and cooling
// - dead zone centred gives zero output
// - zero dead zone switches directly
// - current loop percentages on useful span
// - continuous threshold forces outputs on
// - ramp full scale in configured seconds (group two takes the rate group one had before the last write)
// - binary inputs select group fixed settings
// - fixed setting zero ignores inputs
`include "bps_map.svh"
module bps_top #(
  parameter int IND_CYC = `BPS_IND_CYC,
  parameter int CLK_HZ = `BPS_CLK_HZ
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [7:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic [7:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  input wire logic FIX1_IN,
  input wire logic FIX3_IN,
  input wire logic STEP_OPEN_IN,
  input wire logic STEP_CLOSE_IN,
  input wire logic [7:0] PHASE_POS_IN,
  output logic [7:0] FIRE_OUT,
  output logic [1:0] HC_OUT,
  output logic [3:0] SRC_LAMP_OUT,
  output logic FAIL_OUT,
  output logic SHOW_G2_OUT,
  output logic [6:0] SHOW_PCT_OUT
);
  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [3:0] opmode_r;
  logic [5:0] unitid_r;
  logic [5:0] reprate_r;
  logic [1:0] indsel_r;
  logic [7:0] emu_r;
  logic [3:0] cnt1_r, cnt2_r;
  logic [7:0] phase_r [8];
  logic [6:0] factor_r [2];
  logic [6:0] limit_r [2];
  logic [5:0] dead_r [2];
  logic [6:0] cont_r [2];
  logic [7:0] rate_r [2];
  logic [6:0] fixed_r [2];
  logic [6:0] ctl_pct_r [2];
  logic [1:0] srcsel_r;
  logic loop4_r, manual_r;

  // ---------------------------------------------------------------
  // pin synchronisers, change taken when stages two and three agree
  // ---------------------------------------------------------------
  logic [3:0] pin_raw;
  logic [3:0] s1_r, s2_r, s3_r, pin_r;
  assign pin_raw = {STEP_CLOSE_IN, STEP_OPEN_IN, FIX3_IN, FIX1_IN};
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      s1_r <= 4'h0;
      s2_r <= 4'h0;
      s3_r <= 4'h0;
      pin_r <= 4'h0;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pin_r <= (s2_r & s3_r) | (pin_r & (s2_r | s3_r));
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic aw_hold_r, w_hold_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic do_wr, do_rd, wr_ok, rd_ok;
  logic [7:0] wa;
  logic [31:0] rd_data;
  assign wa = awaddr_r;
  assign do_wr = aw_hold_r && w_hold_r && !S_AXI_BVALID_OUT;
  assign do_rd = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;

  // map decode shared by both channels
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= `BPS_OFF_SETPT);
  endfunction
  assign wr_ok = mapped(wa) && wa != `BPS_OFF_STAT && wa != `BPS_OFF_SETPT;
  assign rd_ok = mapped(S_AXI_ARADDR_IN);

  // address and data latched in either order, reply after both
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 8'h0;
      wdata_r <= 32'h0;
      S_AXI_AWREADY_OUT <= 1'b0;
      S_AXI_WREADY_OUT <= 1'b0;
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT <= 2'b00;
    end else begin
      S_AXI_AWREADY_OUT <= !aw_hold_r && !S_AXI_AWREADY_OUT;
      S_AXI_WREADY_OUT <= !w_hold_r && !S_AXI_WREADY_OUT;
      if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= S_AXI_AWADDR_IN;
      end
      if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
        w_hold_r <= 1'b1;
        wdata_r <= S_AXI_WDATA_IN;
      end
      if (do_wr) begin
        S_AXI_BVALID_OUT <= 1'b1;
        S_AXI_BRESP_OUT <= wr_ok ? 2'b00 : 2'b10;
      end else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
        S_AXI_BVALID_OUT <= 1'b0;
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
      end
    end
  end

  // register writes; fields spread over up to four byte lanes, taken only with all four strobes set
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      opmode_r <= `BPS_RST_OPMODE;
      unitid_r <= `BPS_RST_UNITID;
      reprate_r <= `BPS_RST_REPRATE;
      indsel_r <= 2'h0;
      emu_r <= `BPS_NEW_MODE;
      cnt1_r <= 4'h0;
      cnt2_r <= 4'h0;
      srcsel_r <= 2'h0;
      loop4_r <= 1'b0;
      manual_r <= 1'b0;
      for (int i = 0; i < 8; i++) phase_r[i] <= 8'h0;
      for (int g = 0; g < 2; g++) begin
        factor_r[g] <= `BPS_RST_FACTOR;
        limit_r[g] <= `BPS_RST_LIMIT;
        dead_r[g] <= `BPS_RST_DEAD;
        cont_r[g] <= `BPS_RST_CONT;
        rate_r[g] <= `BPS_RST_RATE;
        fixed_r[g] <= 7'h0;
        ctl_pct_r[g] <= 7'h0;
      end
    end else if (do_wr && wr_ok && S_AXI_WSTRB_IN == 4'hf) begin
      unique case (wa)
        `BPS_OFF_MODE: begin
          opmode_r <= wdata_r[3:0];
          unitid_r <= wdata_r[13:8];
          reprate_r <= wdata_r[21:16];
          indsel_r <= wdata_r[25:24];
          emu_r <= wdata_r[31] ? `BPS_NEW_MODE : `BPS_EMU_MODE;
        end
        `BPS_OFF_COUNT: begin
          cnt1_r <= wdata_r[3:0];
          cnt2_r <= wdata_r[11:8];
        end
        `BPS_OFF_PHASE_LO: begin
          for (int i = 0; i < 4; i++) phase_r[i] <= wdata_r[8*i +: 8];
        end
        `BPS_OFF_PHASE_HI: begin
          for (int i = 0; i < 4; i++) phase_r[i+4] <= wdata_r[8*i +: 8];
        end
        `BPS_OFF_G1, `BPS_OFF_G2: begin
          factor_r[wa[2]] <= wdata_r[6:0];
          limit_r[wa[2]] <= wdata_r[14:8];
          dead_r[wa[2]] <= wdata_r[21:16];
          cont_r[wa[2]] <= wdata_r[30:24];
        end
        `BPS_OFF_SRC: begin
          ctl_pct_r[0] <= wdata_r[6:0];
          ctl_pct_r[1] <= wdata_r[14:8];
          fixed_r[0] <= wdata_r[22:16];
          fixed_r[1] <= wdata_r[30:24];
          rate_r[0] <= {1'b0, wdata_r[7] ? 7'h5a : 7'h1e};
          rate_r[1] <= rate_r[0];
          srcsel_r <= {wdata_r[31], wdata_r[23]};
          loop4_r <= wdata_r[15];
        end
        default: manual_r <= manual_r;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // setting selection per group
  // ---------------------------------------------------------------
  logic [6:0] ramp_pct [2];
  logic [6:0] set_pct [2];
  logic [1:0] fix_on;
  assign fix_on = {pin_r[1], pin_r[0]};
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : grp
      bps_ramp #(.CLK_HZ(CLK_HZ)) u_ramp (
        .clk_in(SYS_CLK_IN),
        .rst_n_in(RST_N_IN),
        .rate_s_in(rate_r[g]),
        .open_in(pin_r[2]),
        .close_in(pin_r[3]),
        .pct_out(ramp_pct[g])
      );
      // step ramp or loop value; fixed value when pin and nonzero
      assign set_pct[g] = (fix_on[g] && fixed_r[g] != 7'h0) ? fixed_r[g] :
                          srcsel_r[g] ? ramp_pct[g] :
                          ctl_pct_r[g];
    end
  endgenerate

  // ---------------------------------------------------------------
  // heating/cooling split with dead zone
  // ---------------------------------------------------------------
  // loop values are percent of the useful span, so the same
  // percentage applies to 0-20 and 4-20 mA alike
  function automatic bps_pkg::bps_zone_t zone_of(input logic [6:0] p,
      input logic [6:0] lim, input logic [5:0] dz);
    logic [7:0] lo, hi;
    lo = {1'b0, lim} - {3'b0, dz[5:1]};
    hi = {1'b0, lim} + {3'b0, dz[5:1]} + {7'b0, dz[0]};
    if (dz == 6'h0)
      zone_of = (p >= lim) ? bps_pkg::BPS_ZONE_HEAT
                           : bps_pkg::BPS_ZONE_COOL;
    else if ({1'b0, p} > hi)
      zone_of = bps_pkg::BPS_ZONE_HEAT;
    else if ({1'b0, p} < lo)
      zone_of = bps_pkg::BPS_ZONE_COOL;
    else
      zone_of = bps_pkg::BPS_ZONE_DEAD;
  endfunction

  bps_pkg::bps_zone_t zone [2];
  logic hc_mode, fact_mode;
  logic [1:0] cont_on;
  assign hc_mode = (opmode_r == 4'd2) || (opmode_r == 4'd4) ||
                   (opmode_r == 4'd6) || (opmode_r == 4'd8);
  assign fact_mode = (opmode_r == 4'd3) || (opmode_r == 4'd4) ||
                     (opmode_r == 4'd7) || (opmode_r == 4'd8);
  generate
    for (g = 0; g < 2; g++) begin : hcz
      assign zone[g] = hc_mode ? zone_of(set_pct[g], limit_r[g], dead_r[g])
                               : bps_pkg::BPS_ZONE_HEAT;
      assign cont_on[g] = cont_r[g] != 7'h0 &&
                          set_pct[g] >= cont_r[g];
    end
  endgenerate

  // ---------------------------------------------------------------
  // output count check and emulation layout
  // ---------------------------------------------------------------
  logic fail;
  logic emu_hc;
  logic [3:0] burners;
  assign fail = ({1'b0, cnt1_r} + {1'b0, cnt2_r}) > 5'd8;
  assign emu_hc = emu_r == `BPS_EMU_MODE &&
                  (opmode_r == 4'd2 || opmode_r == 4'd4);
  assign burners = emu_hc ? 4'd6 : 4'd8;

  // ---------------------------------------------------------------
  // firing: cycle position scaled to 255 steps, phase zero unused
  // ---------------------------------------------------------------
  // position comes already scaled, so phases keep their relation
  // whatever the cycle length
  logic [7:0] fire_nxt;
  logic [1:0] hc_nxt;
  generate
    for (g = 0; g < 8; g++) begin : fire
      localparam int GRP = g % 2;
      assign fire_nxt[g] = !fail && g < burners && phase_r[g] != 8'h0 &&
        zone[GRP] != bps_pkg::BPS_ZONE_DEAD &&
        (cont_on[GRP] || PHASE_POS_IN == phase_r[g]);
    end
  endgenerate
  // heating drives the switch, cooling releases it
  assign hc_nxt = {zone[1] == bps_pkg::BPS_ZONE_HEAT,
                   zone[0] == bps_pkg::BPS_ZONE_HEAT};

  // ---------------------------------------------------------------
  // indicator alternation and lamp flash
  // ---------------------------------------------------------------
  logic [31:0] ind_cnt_r;
  logic ind_tick;
  bps_pkg::bps_show_t show_r;
  bps_pkg::bps_show_t show_nxt;
  assign ind_tick = ind_cnt_r == 32'(IND_CYC - 1);
  assign show_nxt = manual_r ? bps_pkg::bps_show_t'(srcsel_r[1]) :
    indsel_r == 2'd1 ? bps_pkg::BPS_SHOW_G1 :
    indsel_r == 2'd2 ? bps_pkg::BPS_SHOW_G2 :
    (ind_tick ? bps_pkg::bps_show_t'(~show_r) : show_r);

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ind_cnt_r <= 32'h0;
      show_r <= bps_pkg::BPS_SHOW_G1;
      FIRE_OUT <= 8'h0;
      HC_OUT <= 2'h0;
      SRC_LAMP_OUT <= 4'h0;
      FAIL_OUT <= 1'b0;
      SHOW_G2_OUT <= 1'b0;
      SHOW_PCT_OUT <= 7'h0;
    end else begin
      ind_cnt_r <= ind_tick ? 32'h0 : ind_cnt_r + 32'h1;
      show_r <= show_nxt;
      FIRE_OUT <= fire_nxt;
      HC_OUT <= emu_hc ? 2'h0 : hc_nxt;
      // in emulation a bad count keeps switch outputs seven/eight dark as well; HC_OUT stays at zero
      if (emu_hc && !fail) FIRE_OUT[7:6] <= hc_nxt;
      FAIL_OUT <= fail;
      SRC_LAMP_OUT <= fail ? {4{ind_tick ^ SRC_LAMP_OUT[0]}} : 4'h1;
      SHOW_G2_OUT <= show_nxt == bps_pkg::BPS_SHOW_G2;
      SHOW_PCT_OUT <= set_pct[show_nxt];
    end
  end

  // read mux; group words read back as written
  logic rd_grp;
  logic ra_g;
  assign ra_g = S_AXI_ARADDR_IN[2];
  assign rd_grp = S_AXI_ARADDR_IN == `BPS_OFF_G1 ||
                  S_AXI_ARADDR_IN == `BPS_OFF_G2;
  assign rd_data =
    S_AXI_ARADDR_IN == `BPS_OFF_MODE ? {~emu_r[5], 5'h0, indsel_r, 2'h0,
      reprate_r, 2'h0, unitid_r, 4'h0, opmode_r} :
    S_AXI_ARADDR_IN == `BPS_OFF_COUNT ? {20'h0, cnt2_r, 4'h0, cnt1_r} :
    S_AXI_ARADDR_IN == `BPS_OFF_STAT ? {22'h0, fact_mode, fail,
      FIRE_OUT} :
    S_AXI_ARADDR_IN == `BPS_OFF_SETPT ? {17'h0, set_pct[1], 1'b0,
      set_pct[0]} :
    rd_grp ? {1'b0, cont_r[ra_g], 2'h0, dead_r[ra_g], 1'b0,
      limit_r[ra_g], 1'b0, factor_r[ra_g]} : 32'h0;
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      S_AXI_ARREADY_OUT <= 1'b0;
      S_AXI_RVALID_OUT <= 1'b0;
      S_AXI_RDATA_OUT <= 32'h0;
      S_AXI_RRESP_OUT <= 2'b00;
    end else begin
      S_AXI_ARREADY_OUT <= !S_AXI_RVALID_OUT && !S_AXI_ARREADY_OUT;
      if (do_rd) begin
        S_AXI_RVALID_OUT <= 1'b1;
        S_AXI_RDATA_OUT <= rd_data;
        S_AXI_RRESP_OUT <= rd_ok ? 2'b00 : 2'b10;
      end else if (S_AXI_RREADY_IN) begin
        S_AXI_RVALID_OUT <= 1'b0;
      end
    end
  end

  fail_dark_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    fail |=> FIRE_OUT == 8'h0) else $error("fired on bad count");
  fix_use_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (fix_on[0] && fixed_r[0] != 7'h0) |-> set_pct[0] == fixed_r[0])
    else $error("fixed setting ignored");
  emu_hc_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    emu_hc |=> HC_OUT == 2'h0) else $error("switch outputs in emulation");
  show_fixed_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (!manual_r && indsel_r == 2'd1) |=> !SHOW_G2_OUT)
    else $error("indicator left group one");
endmodule

// ==== bps_relay_model.sv ====
/*
  Relay bank model: counts the switch-on events of each firing output.
  Assumes registered fire outputs on the shared system clock.
*/
module bps_relay_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clr_in,
  input wire logic [7:0] fire_in,
  output logic [63:0] hits_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] prev_r;
  // ------------------------------------------------
  // switch-on counting
  // ------------------------------------------------
  // a relay only sees edges, so a held output counts once
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_r <= 8'h00;
      hits_out <= 64'h0;
    end else begin
      prev_r <= fire_in;
      for (int i = 0; i < 8; i++) begin
        if (clr_in)
          hits_out[i*8 +: 8] <= 8'h00;
        else if (fire_in[i] && !prev_r[i])
          hits_out[i*8 +: 8] <= hits_out[i*8 +: 8] + 8'h01;
      end
    end
  end
endmodule

// ==== burner_pulse_scheduler_bench.sv ====
/*
  Self-checking bench of the burner pulse scheduler with a relay bank.
  Assumes short indicator and ramp counts set through parameters.
*/
`include "bps_map.svh"
module burner_pulse_scheduler_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic fix1, fix3, opn, cls, clr;
  logic [7:0] awaddr, araddr, pos;
  logic [31:0] wdata, seed;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, fail, show_g2;
  logic [1:0] bresp, rresp, hc;
  logic [31:0] rdata;
  logic [7:0] fire;
  logic [3:0] lamp;
  logic [6:0] show_pct;
  logic [63:0] hits;
  int failures, n_compared;
  // ------------------------------------------------
  // design and relay bank
  // ------------------------------------------------
  // short counts keep the indicator and ramp runs brief
  bps_top #(.IND_CYC(10), .CLK_HZ(100)) dut_u (
    .SYS_CLK_IN(clk), .RST_N_IN(rst_n),
    .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
    .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
    .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
    .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
    .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
    .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
    .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
    .S_AXI_RREADY_IN(rready), .FIX1_IN(fix1), .FIX3_IN(fix3),
    .STEP_OPEN_IN(opn), .STEP_CLOSE_IN(cls), .PHASE_POS_IN(pos),
    .FIRE_OUT(fire), .HC_OUT(hc), .SRC_LAMP_OUT(lamp),
    .FAIL_OUT(fail), .SHOW_G2_OUT(show_g2), .SHOW_PCT_OUT(show_pct));
  bps_relay_model relay_u (.clk_in(clk), .rst_n_in(rst_n),
    .clr_in(clr), .fire_in(fire), .hits_out(hits));
  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic exp_fail(input int g1, input int g2);
    return (g1 + g2) > 8;
  endfunction
  // only used well outside the dead zone, where the zone edge is moot
  function automatic logic exp_heat(input int pct, input int lim);
    return pct > lim;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    logic ta, tw;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while ((awvalid && !ta) || (wvalid && !tw));
    do @(negedge clk); while (!bvalid);
    r = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask
  // counts level changes of a signal over a number of cycles
  task automatic toggles(input int n, input int which, output int t);
    logic last;
    t = 0;
    last = which ? show_g2 : lamp[0];
    repeat (n) begin
      @(negedge clk);
      if ((which ? show_g2 : lamp[0]) !== last) t++;
      last = which ? show_g2 : lamp[0];
    end
  endtask
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ------------------------------------------------
  // clock, watchdog and scenarios
  // ------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // the whole run takes about 7600 cycles
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    conclude();
  end
  initial begin
    logic [31:0] d, m, f;
    logic [1:0] r;
    int t;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {fix1, fix3, opn, cls, clr} = 5'h00;
    {awaddr, araddr, pos, wdata, wstrb} = '0;
    seed = 32'h9a7e;
    rst_n = 1'b0;
    failures = 0;
    n_compared = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    axr(`BPS_OFF_MODE, d, r);
    chk(d, 32'h80010101);
    axr(`BPS_OFF_G1, d, r);
    chk(d, 32'h00003232);
    for (int i = 0; i < 4; i++) begin
      m = ((xs() % 32 + 1) << 8) | (xs() % 8 + 1) | 32'h00010000;
      axw(`BPS_OFF_MODE, m, r);
      axr(`BPS_OFF_MODE, d, r);
      chk(d, m);
    end
    axw(`BPS_OFF_STAT, 32'h0, r);
    chk({30'h0, r}, 32'h2);
    axr(8'h40, d, r);
    chk({30'h0, r}, 32'h2);
    axw(`BPS_OFF_MODE, 32'h01010101, r);
    for (int g = 4; g < 6; g++) begin
      axw(`BPS_OFF_COUNT, 32'h00000400 | g, r);
      repeat (4) @(posedge clk);
      chk({31'h0, fail}, {31'h0, exp_fail(g, 4)});
    end
    toggles(40, 0, t);
    chk(t >= 3 && t <= 5, 1);
    axw(`BPS_OFF_COUNT, 32'h00000202, r);
    repeat (4) @(posedge clk);
    chk({28'h0, lamp}, 32'h1);
    // outputs five to eight unused, so their phases stay zero
    axw(`BPS_OFF_SRC, 32'h00003232, r);
    axw(`BPS_OFF_PHASE_LO, 32'hbf804000 | (xs() % 255 + 1), r);
    axw(`BPS_OFF_PHASE_HI, 32'h0, r);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    for (int p = 1; p < 256; p++) begin
      @(posedge clk);
      pos <= p[7:0];
    end
    repeat (6) @(posedge clk);
    chk(hits[31:0], 32'h01010101);
    chk(hits[63:32], 32'h0);
    axw(`BPS_OFF_MODE, 32'h81010102, r);
    axw(`BPS_OFF_G1, 32'h000a3232, r);
    for (int s = 20; s <= 80; s += 60) begin
      axw(`BPS_OFF_SRC, 32'h00003200 | s, r);
      repeat (6) @(posedge clk);
      chk({31'h0, hc[0]}, {31'h0, exp_heat(s, 50)});
    end
    axw(`BPS_OFF_MODE, 32'h01010101, r);
    f = xs() % 100 + 1;
    axw(`BPS_OFF_SRC, 32'h0000281e | (f << 16), r);
    @(posedge clk);
    fix1 <= 1'b1;
    repeat (8) @(posedge clk);
    chk({25'h0, show_pct}, f);
    axw(`BPS_OFF_SRC, 32'h0000281e, r);
    repeat (8) @(posedge clk);
    chk({25'h0, show_pct}, 32'h1e);
    axw(`BPS_OFF_MODE, 32'h02010101, r);
    fix3 <= 1'b1;
    repeat (8) @(posedge clk);
    chk({25'h0, show_pct}, 32'h28);
    chk({31'h0, show_g2}, 32'h1);
    fix1 <= 1'b0;
    fix3 <= 1'b0;
    axw(`BPS_OFF_MODE, 32'h00010101, r);
    toggles(60, 1, t);
    chk(t >= 5 && t <= 7, 1);
    // group one follows the step ramp: 30 s is 3000 cycles here
    axw(`BPS_OFF_MODE, 32'h01010101, r);
    axw(`BPS_OFF_SRC, 32'h00800000, r);
    opn <= 1'b1;
    repeat (1500) @(posedge clk);
    chk(show_pct >= 7'd47 && show_pct <= 7'd53, 1);
    repeat (2000) @(posedge clk);
    chk({25'h0, show_pct}, 32'd100);
    opn <= 1'b0;
    cls <= 1'b1;
    repeat (3500) @(posedge clk);
    chk({25'h0, show_pct}, 32'd0);
    cls <= 1'b0;
    conclude();
  end
endmodule
